/* hdl/iox_defs.svh */
// Register indices, field positions and reset values of the expander port block.
// Included by the package user; holds definitions only.
`ifndef IOX_DEFS_SVH
`define IOX_DEFS_SVH

// Register indices; byte address is four times the index
`define IOX_IDX_DIR 4'h0
`define IOX_IDX_CHG_EN 4'h2
`define IOX_IDX_DEFAULT 4'h3
`define IOX_IDX_SRC_SEL 4'h4
`define IOX_IDX_CONFIG 4'h5
`define IOX_IDX_PULLUP 4'h6
`define IOX_IDX_FLAGS 4'h7
`define IOX_IDX_CAPTURE 4'h8
`define IOX_IDX_PORT 4'h9
`define IOX_IDX_LATCH 4'ha

// Index bit that selects port B; bits above it must be zero
`define IOX_PORT_SEL_BIT 4
`define IOX_IDX_HI 7
`define IOX_IDX_LO 5

// Word address inside haddr
`define IOX_HADDR_HI 9
`define IOX_HADDR_LO 2

// Configuration register fields
`define IOX_CFG_MERGE 6
`define IOX_CFG_OPEN_DRAIN 2
`define IOX_CFG_POLARITY 1
`define IOX_CFG_MASK 8'h46

// Reset values
`define IOX_RST_CONFIG 8'h00
`define IOX_RST_DIR 1'b1
`define IOX_RST_CLEAR 1'b0

`endif

/* hdl/iox_pkg.sv */
// Types shared by the expander port block and its bench.
// Assumes iox_defs.svh is included before use of the constants.
package iox_pkg;
	typedef logic [31:0] iox_word_t;
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] idx;
	} iox_req_t;
	typedef enum logic [1:0] {
		IOX_DRV_PP_LOW = 2'h0,
		IOX_DRV_PP_HIGH = 2'h1,
		IOX_DRV_OPEN = 2'h3
	} iox_drive_t;
endpackage : iox_pkg

/* hdl/iox_port_irq.sv */
// Two-port I/O expander port and interrupt logic with an AHB-Lite register slave.
// Assumes pins synchronous-ish inputs from pads, one clock hclk, single word transfers.
//
// How it works
// - Pull-up drives only where its enable bit is set and pin is input.
// - A flag bit sets only for an enabled pin that caused the interrupt.
// - Flag register is read-only; writes to it are discarded.
// - Capture loads pin levels on interrupt, holds until port or capture read.
// - Port read returns pin levels; port write updates the output latch.
// - Latch read returns latch contents; latch write drives output pins.
// - Each port keeps its own interrupt, cleared by its own port/capture read.
// - Merge clear: each port's interrupt goes only to its own output.
// - Merge set: OR of both interrupts drives both outputs.
// - Merged, a read clears only its port; outputs stay until both read.
// - Per-pin source select picks previous value or default-compare bit.
// - Pin-change mode interrupts when enabled pin differs from previous value.
// - Default mode interrupts when enabled pin differs from default bit.
// - Only input pins with change enable can interrupt; outputs never do.
// - Interrupt holds until port/capture read; writes there leave it alone.
// - Clear happens only when the read data has been delivered.
// - While pending, new changes neither interrupt again nor touch capture.
// - Read with change still present clears then reasserts, reloading capture.
// - Pin-change reference becomes the pin level at clear time.
// - Default-mode condition persists while pin differs, even after a read.
// - Interrupt output drives active-low, active-high push-pull or open-drain.
// - Open-drain set overrides polarity; polarity only acts in push-pull.
`timescale 1ns/1ps
`include "iox_defs.svh"

module iox_port_irq #(
	parameter int PORT_W = 8
) (
	// Clock, reset, enable
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire iox_pkg::iox_word_t hwdata,
	input wire logic hready,
	output iox_pkg::iox_word_t hrdata,
	output logic hreadyout,
	output logic hresp,
	// Port A pins
	input wire logic [PORT_W-1:0] port_a_pins_in,
	output logic [PORT_W-1:0] port_a_pins_out,
	output logic [PORT_W-1:0] port_a_pins_oe,
	output logic [PORT_W-1:0] port_a_pullup,
	// Port B pins
	input wire logic [PORT_W-1:0] port_b_pins_in,
	output logic [PORT_W-1:0] port_b_pins_out,
	output logic [PORT_W-1:0] port_b_pins_oe,
	output logic [PORT_W-1:0] port_b_pullup,
	// Interrupt pads
	output logic irq_out_a,
	output logic irq_out_a_oe,
	output logic irq_out_b,
	output logic irq_out_b_oe
);
	import iox_pkg::*;

	initial begin
		if (PORT_W < 1 || PORT_W > 8) begin
			$error("PORT_W must be 1 to 8");
		end
	end

	// Per-port register storage, index 0 = port A, 1 = port B; config register shared
	logic [PORT_W-1:0] direction_reg [2];
	logic [PORT_W-1:0] change_irq_enable_reg [2];
	logic [PORT_W-1:0] compare_default_reg [2];
	logic [PORT_W-1:0] irq_source_select_reg [2];
	logic [PORT_W-1:0] pullup_enable_reg [2];
	logic [PORT_W-1:0] irq_flag_reg [2];
	logic [PORT_W-1:0] irq_capture_reg [2];
	logic [PORT_W-1:0] output_latch_reg [2];
	logic [7:0] expander_config_reg;

	// Synchroniser and change detection state
	logic [PORT_W-1:0] pin_meta [2];
	logic [PORT_W-1:0] pin_level [2];
	logic [PORT_W-1:0] change_ref [2];
	logic [1:0] irq_pending;

	// Bus pipeline, plus combinational pin, interrupt and config signals
	iox_req_t req_q;
	logic [1:0] read_clear;
	logic [PORT_W-1:0] pin_raw [2];
	logic [PORT_W-1:0] change_cond [2];
	logic [1:0] clear_now;
	logic [1:0] irq_active;
	logic [1:0] raise_now;
	iox_req_t next_req;
	logic open_drain_bit;
	logic irq_polarity_bit;
	logic merge_bit;

	function automatic logic idx_mapped(input logic [7:0] idx);
		idx_mapped = (idx[`IOX_IDX_HI:`IOX_IDX_LO] == 3'h0);
	endfunction : idx_mapped

	function automatic logic idx_port(input logic [7:0] idx);
		idx_port = idx[`IOX_PORT_SEL_BIT];
	endfunction : idx_port

	// Reads that hand over the interrupt state and so clear it
	function automatic logic clears_irq(input logic [7:0] idx);
		clears_irq = idx_mapped(idx) && (idx[3:0] == `IOX_IDX_CAPTURE
			|| idx[3:0] == `IOX_IDX_PORT);
	endfunction : clears_irq

	// Interrupt pad level and enable for one active level
	function automatic logic [1:0] pad_drive(input logic act, input logic od,
			input logic pol);
		if (od) begin
			pad_drive = {act, 1'b0};
		end else begin
			pad_drive = {1'b1, pol ? act : ~act};
		end
	endfunction : pad_drive

	assign pin_raw[0] = port_a_pins_in;
	assign pin_raw[1] = port_b_pins_in;
	assign open_drain_bit = expander_config_reg[`IOX_CFG_OPEN_DRAIN];
	assign irq_polarity_bit = expander_config_reg[`IOX_CFG_POLARITY];
	assign merge_bit = expander_config_reg[`IOX_CFG_MERGE];
	assign clear_now = read_clear;

	always_comb begin
		next_req.idx = haddr[`IOX_HADDR_HI:`IOX_HADDR_LO];
		next_req.rd = hsel & hready & htrans[1] & ~hwrite;
		next_req.wr = hsel & hready & htrans[1] & hwrite;
	end

	// Change conditions per port
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			change_cond[p] = change_irq_enable_reg[p] & direction_reg[p]
				& ((irq_source_select_reg[p] & (pin_level[p] ^ compare_default_reg[p]))
				| (~irq_source_select_reg[p] & (pin_level[p] ^ change_ref[p])));
		end
	end

	// Merged routing: OR onto both pads, else own port only
	always_comb begin
		if (merge_bit) begin
			irq_active = {2{|irq_pending}};
		end else begin
			irq_active = irq_pending;
		end
	end

	// Pin synchroniser
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int p = 0; p < 2; p++) begin
				pin_meta[p] <= '0;
				pin_level[p] <= '0;
			end
		end else if (ce) begin
			for (int p = 0; p < 2; p++) begin
				pin_meta[p] <= pin_raw[p];
				pin_level[p] <= pin_meta[p];
			end
		end
	end

	// Bus response: zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_q <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else if (ce) begin
			req_q <= next_req;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Port and capture reads clear that port at the end of the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			read_clear <= 2'b00;
		end else if (ce) begin
			read_clear <= 2'b00;
			if (next_req.rd && clears_irq(next_req.idx)) begin
				read_clear[idx_port(next_req.idx)] <= 1'b1;
			end
		end
	end

	// Read data registered at the address edge, held through the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
		end else if (ce && next_req.rd) begin
			hrdata <= '0;
			if (!idx_mapped(next_req.idx)) begin
				hrdata <= '0;
			end else if (next_req.idx[3:0] == `IOX_IDX_DIR) begin
				hrdata[PORT_W-1:0] <= direction_reg[idx_port(next_req.idx)];
			end else if (next_req.idx[3:0] == `IOX_IDX_CHG_EN) begin
				hrdata[PORT_W-1:0] <= change_irq_enable_reg[idx_port(next_req.idx)];
			end else if (next_req.idx[3:0] == `IOX_IDX_DEFAULT) begin
				hrdata[PORT_W-1:0] <= compare_default_reg[idx_port(next_req.idx)];
			end else if (next_req.idx[3:0] == `IOX_IDX_SRC_SEL) begin
				hrdata[PORT_W-1:0] <= irq_source_select_reg[idx_port(next_req.idx)];
			end else if (next_req.idx[3:0] == `IOX_IDX_CONFIG) begin
				hrdata[7:0] <= expander_config_reg;
			end else if (next_req.idx[3:0] == `IOX_IDX_PULLUP) begin
				hrdata[PORT_W-1:0] <= pullup_enable_reg[idx_port(next_req.idx)];
			end else if (next_req.idx[3:0] == `IOX_IDX_FLAGS) begin
				hrdata[PORT_W-1:0] <= irq_flag_reg[idx_port(next_req.idx)];
			end else if (next_req.idx[3:0] == `IOX_IDX_CAPTURE) begin
				hrdata[PORT_W-1:0] <= irq_capture_reg[idx_port(next_req.idx)];
			end else if (next_req.idx[3:0] == `IOX_IDX_PORT) begin
				hrdata[PORT_W-1:0] <= pin_level[idx_port(next_req.idx)];
			end else if (next_req.idx[3:0] == `IOX_IDX_LATCH) begin
				hrdata[PORT_W-1:0] <= output_latch_reg[idx_port(next_req.idx)];
			end
		end
	end

	// Register writes in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			expander_config_reg <= `IOX_RST_CONFIG;
			for (int p = 0; p < 2; p++) begin
				direction_reg[p] <= {PORT_W{`IOX_RST_DIR}};
				change_irq_enable_reg[p] <= {PORT_W{`IOX_RST_CLEAR}};
				compare_default_reg[p] <= {PORT_W{`IOX_RST_CLEAR}};
				irq_source_select_reg[p] <= {PORT_W{`IOX_RST_CLEAR}};
				pullup_enable_reg[p] <= {PORT_W{`IOX_RST_CLEAR}};
				output_latch_reg[p] <= {PORT_W{`IOX_RST_CLEAR}};
			end
		end else if (ce && req_q.wr && idx_mapped(req_q.idx)) begin
			// Flag and capture writes fall through and are dropped
			if (req_q.idx[3:0] == `IOX_IDX_DIR) begin
				direction_reg[idx_port(req_q.idx)] <= hwdata[PORT_W-1:0];
			end else if (req_q.idx[3:0] == `IOX_IDX_CHG_EN) begin
				change_irq_enable_reg[idx_port(req_q.idx)] <= hwdata[PORT_W-1:0];
			end else if (req_q.idx[3:0] == `IOX_IDX_DEFAULT) begin
				compare_default_reg[idx_port(req_q.idx)] <= hwdata[PORT_W-1:0];
			end else if (req_q.idx[3:0] == `IOX_IDX_SRC_SEL) begin
				irq_source_select_reg[idx_port(req_q.idx)] <= hwdata[PORT_W-1:0];
			end else if (req_q.idx[3:0] == `IOX_IDX_CONFIG) begin
				expander_config_reg <= hwdata[7:0] & `IOX_CFG_MASK;
			end else if (req_q.idx[3:0] == `IOX_IDX_PULLUP) begin
				pullup_enable_reg[idx_port(req_q.idx)] <= hwdata[PORT_W-1:0];
			end else if (req_q.idx[3:0] == `IOX_IDX_PORT) begin
				output_latch_reg[idx_port(req_q.idx)] <= hwdata[PORT_W-1:0];
			end else if (req_q.idx[3:0] == `IOX_IDX_LATCH) begin
				output_latch_reg[idx_port(req_q.idx)] <= hwdata[PORT_W-1:0];
			end
		end
	end

	// Raise on a condition when idle, or at once on a clear that still sees one,
	// so an event is never lost across the read
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			raise_now[p] = (|change_cond[p]) & (clear_now[p] | ~irq_pending[p]);
		end
	end

	// Pending holds until a port or capture read; writes never touch it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_pending <= 2'b00;
		end else if (ce) begin
			irq_pending <= raise_now | (irq_pending & ~clear_now);
		end
	end

	// Flags show the causing pins; a clear with no condition empties them
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int p = 0; p < 2; p++) begin
				irq_flag_reg[p] <= '0;
			end
		end else if (ce) begin
			for (int p = 0; p < 2; p++) begin
				if (raise_now[p] || clear_now[p]) begin
					irq_flag_reg[p] <= change_cond[p];
				end
			end
		end
	end

	// Capture loads only when an interrupt rises; a pending one keeps it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int p = 0; p < 2; p++) begin
				irq_capture_reg[p] <= '0;
			end
		end else if (ce) begin
			for (int p = 0; p < 2; p++) begin
				if (raise_now[p]) begin
					irq_capture_reg[p] <= pin_level[p];
				end
			end
		end
	end

	// Pin-change reference tracks the pins while idle and restarts at a clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int p = 0; p < 2; p++) begin
				change_ref[p] <= '0;
			end
		end else if (ce) begin
			for (int p = 0; p < 2; p++) begin
				if (clear_now[p] || !irq_pending[p]) begin
					change_ref[p] <= pin_level[p];
				end
			end
		end
	end

	// Port A pin drivers, all registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_a_pins_out <= '0;
			port_a_pins_oe <= '0;
			port_a_pullup <= '0;
		end else if (ce) begin
			port_a_pins_out <= output_latch_reg[0];
			port_a_pins_oe <= ~direction_reg[0];
			port_a_pullup <= pullup_enable_reg[0] & direction_reg[0];
		end
	end

	// Port B pin drivers, all registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_b_pins_out <= '0;
			port_b_pins_oe <= '0;
			port_b_pullup <= '0;
		end else if (ce) begin
			port_b_pins_out <= output_latch_reg[1];
			port_b_pins_oe <= ~direction_reg[1];
			port_b_pullup <= pullup_enable_reg[1] & direction_reg[1];
		end
	end

	// Interrupt pad A; reset shows inactive push-pull active-low
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_out_a <= 1'b1;
			irq_out_a_oe <= 1'b1;
		end else if (ce) begin
			{irq_out_a_oe, irq_out_a} <= pad_drive(irq_active[0], open_drain_bit,
				irq_polarity_bit);
		end
	end

	// Interrupt pad B, same drive rules as pad A
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_out_b <= 1'b1;
			irq_out_b_oe <= 1'b1;
		end else if (ce) begin
			{irq_out_b_oe, irq_out_b} <= pad_drive(irq_active[1], open_drain_bit,
				irq_polarity_bit);
		end
	end
endmodule : iox_port_irq

/* verif/iox_port_irq_sva.sv */
// Checker of the expander port block: bus answers, pins and interrupt pads.
// Bound to iox_port_irq; sees its ports only.
`timescale 1ns/1ps
module iox_port_irq_sva #(
	parameter int PORT_W = 8
) (
	// Clock and bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire iox_pkg::iox_word_t hwdata,
	input wire iox_pkg::iox_word_t hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Pins and pads
	input wire logic [PORT_W-1:0] port_a_pins_in,
	input wire logic [PORT_W-1:0] port_a_pins_out,
	input wire logic [PORT_W-1:0] port_a_pins_oe,
	input wire logic [PORT_W-1:0] port_a_pullup,
	input wire logic [PORT_W-1:0] port_b_pins_in,
	input wire logic [PORT_W-1:0] port_b_pins_oe,
	input wire logic [PORT_W-1:0] port_b_pullup,
	input wire logic irq_out_a,
	input wire logic irq_out_a_oe,
	input wire logic irq_out_b,
	input wire logic irq_out_b_oe
);
	import iox_pkg::*;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic tk;
	logic [7:0] ix;
	logic [PORT_W-1:0] wlo;
	logic [2:0] quiet;
	assign tk = hsel && hready && htrans[1] && ce;
	assign ix = haddr[9:2];
	assign wlo = hwdata[PORT_W-1:0];
	// Pads move at most four edges after a cause, so six quiet edges mean frozen
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			quiet <= 3'h0;
		end else if (tk || $changed(port_a_pins_in) || $changed(port_b_pins_in)) begin
			quiet <= 3'h0;
		end else if (quiet != 3'h7) begin
			quiet <= quiet + 3'h1;
		end
	end
	AST_ZERO_WAIT: assert property (hreadyout && !hresp) else $error("bus stalled or failed");
	AST_PULLUP_A: assert property ((port_a_pullup & port_a_pins_oe) == '0)
		else $error("pull-up on driven pin a");
	AST_PULLUP_B: assert property ((port_b_pullup & port_b_pins_oe) == '0)
		else $error("pull-up on driven pin b");
	AST_PORT_READ_A: assert property (tk && !hwrite && ix == 8'h09
		&& $stable(port_a_pins_in) && port_a_pins_in == $past(port_a_pins_in, 2)
		|=> hrdata[PORT_W-1:0] == $past(port_a_pins_in)) else $error("port read not pins");
	AST_LATCH_PINS_A: assert property (tk && hwrite && (ix == 8'h09 || ix == 8'h0a)
		|=> ##2 port_a_pins_out == $past(wlo, 2)) else $error("pins a miss latch write");
	AST_PAD_A_DRIVE: assert property (irq_out_a |-> irq_out_a_oe)
		else $error("pad a high while released");
	AST_PAD_B_DRIVE: assert property ($fell(irq_out_b_oe) |-> !irq_out_b)
		else $error("pad b released high");
	AST_PAD_STILL: assert property (quiet >= 3'h6
		|-> $stable({irq_out_a, irq_out_a_oe, irq_out_b, irq_out_b_oe})) else $error("pad moved");
	cover property (!irq_out_a && irq_out_a_oe);
	cover property (irq_out_b && irq_out_b_oe);
	cover property ($fell(irq_out_a_oe));
endmodule : iox_port_irq_sva

bind iox_port_irq iox_port_irq_sva #(.PORT_W(PORT_W)) u_sva (.hclk, .hresetn, .ce, .hsel,
	.haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .port_a_pins_in,
	.port_a_pins_out, .port_a_pins_oe, .port_a_pullup, .port_b_pins_in, .port_b_pins_oe,
	.port_b_pullup, .irq_out_a, .irq_out_a_oe, .irq_out_b, .irq_out_b_oe);

/* verif/iox_pin_world.sv */
// Board side of one expander port: external drivers on the pins.
// Assumes the board drives every pin the device releases.
`timescale 1ns/1ps
module iox_pin_world #(
	parameter int PORT_W = 8
) (
	// Device side
	input wire logic [PORT_W-1:0] pins_out,
	input wire logic [PORT_W-1:0] pins_oe,
	// Board side
	input wire logic [PORT_W-1:0] ext_val,
	output logic [PORT_W-1:0] pins_in
);
	assign pins_in = (pins_oe & pins_out) | (~pins_oe & ext_val);
endmodule : iox_pin_world

/* verif/tb.sv */
// Bench of the expander port block: AHB-Lite master tasks and scenarios.
// Pin worlds stand for the boards on both ports; the checker is bound.
`timescale 1ns/1ps
module tb;
	import iox_pkg::*;
	logic hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	iox_word_t hwdata, hrdata;
	logic [7:0] port_a_pins_in, port_a_pins_out, port_a_pins_oe, port_a_pullup, ext_a;
	logic [7:0] port_b_pins_in, port_b_pins_out, port_b_pins_oe, port_b_pullup, ext_b;
	logic irq_out_a, irq_out_a_oe, irq_out_b, irq_out_b_oe;
	int fail_count = 0;
	int samples_checked = 0;
	iox_port_irq uut (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .port_a_pins_in, .port_a_pins_out,
		.port_a_pins_oe, .port_a_pullup, .port_b_pins_in, .port_b_pins_out, .port_b_pins_oe,
		.port_b_pullup, .irq_out_a, .irq_out_a_oe, .irq_out_b, .irq_out_b_oe);
	iox_pin_world pw_a (.pins_out(port_a_pins_out), .pins_oe(port_a_pins_oe), .ext_val(ext_a),
		.pins_in(port_a_pins_in));
	iox_pin_world pw_b (.pins_out(port_b_pins_out), .pins_oe(port_b_pins_oe), .ext_val(ext_b),
		.pins_in(port_b_pins_in));
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", name, exp, got);
			fail_count++;
		end
	endtask : chk
	// Address phase held until hready, then data phase held until hready
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		output logic [7:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {22'h0, idx, 2'h0};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata[7:0];
	endtask : xfer
	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		logic [7:0] d;
		xfer(1'b1, idx, wd, d);
	endtask : wr
	task automatic rdc(input string name, input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] d;
		xfer(1'b0, idx, 8'h00, d);
		chk(name, exp, d);
	endtask : rdc
	task automatic t_reset();
		rdc("pullup_a", 8'h06, 8'h00);
		rdc("port_a", 8'h09, 8'h00);
		rdc("latch_b", 8'h1a, 8'h00);
		wr(8'h07, 8'hff);
		rdc("flags_a", 8'h07, 8'h00);
		rdc("unmapped", 8'h0b, 8'h00);
	endtask : t_reset
	task automatic t_latch();
		ext_a <= 8'h5a;
		wr(8'h00, 8'h0f);
		wr(8'h09, 8'ha5);
		rdc("latch_a", 8'h0a, 8'ha5);
		wr(8'h0a, 8'h3c);
		wr(8'h06, 8'hff);
		repeat (3) @(posedge hclk);
		rdc("port_a", 8'h09, 8'h3a);
		chk("pins_out_a", 8'h3c, port_a_pins_out);
		chk("pullup_a", 8'h0f, port_a_pullup);
		wr(8'h1a, 8'h99);
		repeat (2) @(posedge hclk);
		chk("pins_out_b", 8'h99, port_b_pins_out);
		chk("oe_a", 8'hf0, port_a_pins_oe);
	endtask : t_latch
	task automatic t_pin_change();
		wr(8'h00, 8'hfb);
		wr(8'h0a, 8'h04);
		wr(8'h04, 8'h00);
		repeat (6) @(posedge hclk);
		wr(8'h02, 8'h05);
		wr(8'h0a, 8'h00);
		repeat (6) @(posedge hclk);
		chk("irq_a_idle", 8'h01, {7'h0, irq_out_a});
		ext_a <= 8'h5b;
		repeat (6) @(posedge hclk);
		chk("irq_a_set", 8'h00, {7'h0, irq_out_a});
		rdc("flags_a", 8'h07, 8'h01);
		ext_a <= 8'h5a;
		wr(8'h09, 8'h00);
		repeat (6) @(posedge hclk);
		chk("irq_a_held", 8'h00, {7'h0, irq_out_a});
		rdc("capture_a", 8'h08, 8'h5b);
		repeat (6) @(posedge hclk);
		chk("irq_a_again", 8'h00, {7'h0, irq_out_a});
		rdc("capture_a2", 8'h08, 8'h5a);
		repeat (6) @(posedge hclk);
		chk("irq_a_clear", 8'h01, {7'h0, irq_out_a});
	endtask : t_pin_change
	task automatic t_default_merge();
		wr(8'h10, 8'hff);
		wr(8'h14, 8'h80);
		wr(8'h13, 8'h00);
		wr(8'h12, 8'h80);
		ext_b <= 8'h80;
		repeat (6) @(posedge hclk);
		chk("irq_own", 8'h02, {6'h0, irq_out_a, irq_out_b});
		ext_b <= 8'h81;
		repeat (6) @(posedge hclk);
		rdc("port_b", 8'h19, 8'h81);
		rdc("capture_b", 8'h18, 8'h81);
		chk("irq_stay", 8'h02, {6'h0, irq_out_a, irq_out_b});
		wr(8'h05, 8'h40);
		repeat (3) @(posedge hclk);
		chk("irq_merge", 8'h00, {6'h0, irq_out_a, irq_out_b});
		wr(8'h05, 8'h42);
		repeat (3) @(posedge hclk);
		chk("irq_high", 8'h03, {6'h0, irq_out_a, irq_out_b});
		wr(8'h15, 8'h46);
		ext_a <= 8'h5b;
		ext_b <= 8'h00;
		repeat (6) @(posedge hclk);
		chk("irq_open", 8'h0c, {4'h0, irq_out_a_oe, irq_out_b_oe, irq_out_a, irq_out_b});
		rdc("port_b2", 8'h19, 8'h00);
		repeat (3) @(posedge hclk);
		chk("irq_one", 8'h0c, {4'h0, irq_out_a_oe, irq_out_b_oe, irq_out_a, irq_out_b});
		rdc("port_a2", 8'h09, 8'h5b);
		repeat (3) @(posedge hclk);
		chk("irq_both", 8'h00, {4'h0, irq_out_a_oe, irq_out_b_oe, irq_out_a, irq_out_b});
	endtask : t_default_merge
	task automatic tally_and_finish();
		$display("Checks %0d, errors %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	// Whole run is about 150 cycles; ten thousand means a hang
	initial begin
		#1000000;
		fail_count++;
		tally_and_finish();
	end
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata, ext_a, ext_b} = '0;
		ce = 1'b1;
		hsize = 3'h2;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		t_reset();
		t_latch();
		t_pin_change();
		t_default_merge();
		tally_and_finish();
	end
endmodule : tb
